// ---- ics_top.sv ----
// Purpose: Injection command output stage between processor and drivers.
// Assumes: One 10 MHz clock, asynchronous active-low reset, Avalon-MM slave.
// Notes:   Pins from outside pass two flip-flops before use.
//
// Overview of operation
// RULE_01 - The ten processor injection lines are split into twenty per-cylinder commands.
// RULE_02 - A watchdog timeout halts the processor and locks the command, drive, pulse and discrete outputs inactive.
// RULE_03 - Test mode makes internal speed pulses of 37.5 rpm on a 60-tooth wheel.
// RULE_04 - Each solenoid is energised only while its command is active.
// RULE_05 - A command's leading edge starts its pull-in and hold-in timers together.
// RULE_06 - The pull-in time is selectable from one to four milliseconds.
// RULE_07 - Energised time is capped at 450 ms even if the command stays active.
// RULE_08 - After pull-in, current feedback chops the drive to hold the lower current.
// RULE_09 - Processor writes configure this block; reads and writes decode memory-mapped I/O selects.
// RULE_10 - The running indicator is lit while the processor runs and dark after a halt.
// RULE_11 - Each discrete-output indicator lights while its output is high.
// RULE_12 - The network indicator lights on field network traffic.
// RULE_13 - Each pickup pulse is armed on its rising edge and delivered on its falling edge.
// RULE_14 - In four-cycle mode only the centre pulse right after a phase pulse is passed on.
// RULE_15 - The processor drives ten lines, each carrying two complementary cylinders.
// RULE_16 - The output lock persists until reset.
module ics_top #(
  parameter int P_MS_CYC    = ics_pkg::MS_CYC,
  parameter int P_HOLD_CYC  = ics_pkg::HOLD_MAX_CYC,
  parameter int P_TEST_HALF = int'(ics_pkg::TEST_HALF_CYC),
  parameter int P_WDOG_CYC  = ics_pkg::WDOG_CYC
) (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RESETN,
  input  wire logic [7:0]                    I_AVS_ADDRESS,
  input  wire logic                          I_AVS_READ,
  input  wire logic                          I_AVS_WRITE,
  input  wire logic [31:0]                   I_AVS_WRITEDATA,
  output logic      [31:0]                   O_AVS_READDATA,
  output logic                               O_AVS_WAITREQUEST,
  input  wire logic [ics_pkg::NUM_LINES-1:0] I_INJ_LINE,
  input  wire logic [ics_pkg::NUM_CH-1:0]    I_CUR_HIGH,
  input  wire logic                          I_SPEED_PICKUP,
  input  wire logic                          I_TOP_DEAD_CENTRE_PULSE,
  input  wire logic                          I_PHASE_PICKUP,
  input  wire logic                          I_NET_ACTIVITY,
  output logic      [ics_pkg::NUM_CH-1:0]    O_INJ_CMD,
  output logic      [ics_pkg::NUM_CH-1:0]    O_SOL_DRIVE,
  output logic                               O_SPEED_EVT,
  output logic                               O_TDC_EVT,
  output logic                               O_CPU_HALT,
  output logic                               O_IO_LOCK,
  output logic      [ics_pkg::MMIO_NUM-1:0]  O_MMIO_SEL,
  output logic                               O_SUPPLY_PRESENT_INDICATOR,
  output logic                               O_CPU_RUN_INDICATOR,
  output logic                               O_DISCRETE_OUT_ONE,
  output logic                               O_DISCRETE_OUT_TWO,
  output logic                               O_DO_ONE_INDICATOR,
  output logic                               O_DO_TWO_INDICATOR,
  output logic                               O_FIELD_NETWORK_INDICATOR,
  output logic                               O_IRQ
);
  ics_drv_if drv_if ();

  logic [ics_pkg::NUM_LINES-1:0] line_s1_ff;
  logic [ics_pkg::NUM_LINES-1:0] line_s2_ff;
  logic [ics_pkg::NUM_LINES-1:0] line_d_ff;
  logic [ics_pkg::NUM_LINES-1:0] bank_ff;
  logic [ics_pkg::NUM_CH-1:0]    cur_s1_ff;
  logic [ics_pkg::NUM_CH-1:0]    cur_s2_ff;
  logic [ics_pkg::NUM_CH-1:0]    nxt_cmd;
  logic [1:0]                    net_s_ff;
  logic [ics_pkg::CTRL_W-1:0]    ctrl_ff;
  logic [ics_pkg::IRQ_W-1:0]     irq_stat_ff;
  logic [ics_pkg::IRQ_W-1:0]     irq_mask_ff;
  logic [ics_pkg::IRQ_W-1:0]     irq_set;
  logic                          lock_ff;
  logic [31:0]                   wdog_ff;
  logic [31:0]                   test_cnt_ff;
  logic                          test_lvl_ff;
  logic                          phase_seen_ff;
  logic                          speed_evt;
  logic                          tdc_evt;
  logic                          phase_evt;
  logic                          acc;
  logic                          wr;
  logic                          kick;
  logic                          bank_clr;
  logic [31:0]                   nxt_rdata;
  ics_pkg::ics_bus_st_t          bus_st_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave: one wait cycle, then the access is taken.

  assign acc = (bus_st_ff == ics_pkg::BUS_ANSWER) && (I_AVS_READ || I_AVS_WRITE);
  assign wr  = acc && I_AVS_WRITE;
  assign kick     = wr && (I_AVS_ADDRESS == ics_pkg::ADDR_KICK);
  assign bank_clr = wr && (I_AVS_ADDRESS == ics_pkg::ADDR_BANK_CLR);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (I_AVS_ADDRESS)
      ics_pkg::ADDR_CTRL:     nxt_rdata[ics_pkg::CTRL_W-1:0] = ctrl_ff;
      ics_pkg::ADDR_STATUS:   begin
        nxt_rdata[ics_pkg::STAT_LOCK]      = lock_ff;
        nxt_rdata[ics_pkg::STAT_PHASE_ARM] = phase_seen_ff;
      end
      ics_pkg::ADDR_IRQ_STAT: nxt_rdata[ics_pkg::IRQ_W-1:0] = irq_stat_ff;
      ics_pkg::ADDR_IRQ_MASK: nxt_rdata[ics_pkg::IRQ_W-1:0] = irq_mask_ff;
      ics_pkg::ADDR_DRIVE:    nxt_rdata[ics_pkg::NUM_CH-1:0] = drv_if.drive;
      ics_pkg::ADDR_CMD:      nxt_rdata[ics_pkg::NUM_CH-1:0] = O_INJ_CMD;
      default:                nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bus_st_ff         <= ics_pkg::BUS_IDLE;
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA    <= 32'h0000_0000;
    end else begin
      unique case (bus_st_ff)
        ics_pkg::BUS_IDLE: begin
          if (I_AVS_READ || I_AVS_WRITE) begin
            bus_st_ff         <= ics_pkg::BUS_ANSWER;
            O_AVS_WAITREQUEST <= 1'b0;
            O_AVS_READDATA    <= I_AVS_READ ? nxt_rdata : 32'h0000_0000;
          end
        end
        ics_pkg::BUS_ANSWER: begin
          bus_st_ff         <= ics_pkg::BUS_IDLE;
          O_AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_st_ff         <= ics_pkg::BUS_IDLE;
          O_AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_ff     <= ics_pkg::CTRL_RST;
      irq_mask_ff <= '0;
      O_MMIO_SEL  <= '0;
    end else begin
      O_MMIO_SEL <= '0;
      if (wr && I_AVS_ADDRESS == ics_pkg::ADDR_CTRL) begin
        ctrl_ff <= I_AVS_WRITEDATA[ics_pkg::CTRL_W-1:0]; // [RULE_09]
      end
      if (wr && I_AVS_ADDRESS == ics_pkg::ADDR_IRQ_MASK) begin
        irq_mask_ff <= I_AVS_WRITEDATA[ics_pkg::IRQ_W-1:0];
      end
      if (acc && I_AVS_ADDRESS[7:6] == ics_pkg::MMIO_TOP) begin
        O_MMIO_SEL[I_AVS_ADDRESS[3:2]] <= 1'b1; // [RULE_09]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins over clear.

  assign irq_set = {speed_evt, drv_if.hold_hit, O_TDC_EVT, lock_ff};

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_stat_ff <= '0;
      O_IRQ       <= 1'b0;
    end else begin
      for (int b = 0; b < ics_pkg::IRQ_W; b++) begin
        if (wr && I_AVS_ADDRESS == ics_pkg::ADDR_IRQ_STAT && I_AVS_WRITEDATA[b]) begin
          irq_stat_ff[b] <= 1'b0;
        end
        if (irq_set[b]) irq_stat_ff[b] <= 1'b1;
      end
      O_IRQ <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and output lock.

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wdog_ff <= 32'h0000_0000;
      lock_ff <= 1'b0;
    end else begin
      if (kick || !ctrl_ff[ics_pkg::CTRL_WDOG_EN]) begin
        wdog_ff <= 32'h0000_0000;
      end else if (!lock_ff) begin
        wdog_ff <= wdog_ff + 32'h0000_0001;
        if (wdog_ff + 32'h0000_0001 >= 32'(P_WDOG_CYC)) begin
          lock_ff <= 1'b1; // [RULE_02] [RULE_16]
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CPU_HALT                 <= 1'b0;
      O_IO_LOCK                  <= 1'b0;
      O_CPU_RUN_INDICATOR        <= 1'b0;
      O_SUPPLY_PRESENT_INDICATOR <= 1'b0;
    end else begin
      O_CPU_HALT                 <= lock_ff; // [RULE_02]
      O_IO_LOCK                  <= lock_ff; // [RULE_02]
      O_CPU_RUN_INDICATOR        <= !lock_ff; // [RULE_10]
      O_SUPPLY_PRESENT_INDICATOR <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Injection line demultiplexing and driver hand-off.

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      line_s1_ff <= '0;
      line_s2_ff <= '0;
      line_d_ff  <= '0;
      bank_ff    <= '0;
      cur_s1_ff  <= '0;
      cur_s2_ff  <= '0;
      O_INJ_CMD  <= '0;
    end else begin
      line_s1_ff <= I_INJ_LINE;
      line_s2_ff <= line_s1_ff;
      line_d_ff  <= line_s2_ff;
      cur_s1_ff  <= I_CUR_HIGH;
      cur_s2_ff  <= cur_s1_ff;
      O_INJ_CMD  <= nxt_cmd;
      for (int l = 0; l < ics_pkg::NUM_LINES; l++) begin
        if (bank_clr) begin
          bank_ff[l] <= 1'b0;
        end else if (line_d_ff[l] && !line_s2_ff[l]) begin
          bank_ff[l] <= !bank_ff[l]; // [RULE_15]
        end
      end
    end
  end

  always_comb begin
    nxt_cmd = '0;
    for (int l = 0; l < ics_pkg::NUM_LINES; l++) begin
      nxt_cmd[2*l + int'(bank_ff[l])] = line_s2_ff[l] && !lock_ff; // [RULE_01] [RULE_16]
    end
  end

  assign drv_if.cmd      = O_INJ_CMD;
  assign drv_if.cur_high = cur_s2_ff;
  assign drv_if.lock     = lock_ff;
  assign drv_if.pull_cyc =
    ics_pkg::ics_pull_cyc(ctrl_ff[ics_pkg::CTRL_PULL_LO +: 2], P_MS_CYC); // [RULE_06]

  ics_driver #(.P_HOLD_CYC(P_HOLD_CYC)) u_driver (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .bus      (drv_if.drv)
  );

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SOL_DRIVE <= '0;
    end else begin
      O_SOL_DRIVE <= lock_ff ? '0 : drv_if.drive; // [RULE_02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed, centre and phase pulses, with the test-mode tooth generator.

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      test_cnt_ff <= 32'h0000_0000;
      test_lvl_ff <= 1'b0;
    end else if (!ctrl_ff[ics_pkg::CTRL_TEST]) begin
      test_cnt_ff <= 32'h0000_0000;
      test_lvl_ff <= 1'b0;
    end else if (test_cnt_ff + 32'h0000_0001 >= 32'(P_TEST_HALF)) begin
      test_cnt_ff <= 32'h0000_0000;
      test_lvl_ff <= !test_lvl_ff; // [RULE_03]
    end else begin
      test_cnt_ff <= test_cnt_ff + 32'h0000_0001;
    end
  end

  ics_pulse u_speed (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_pin     (I_SPEED_PICKUP),
    .i_use_alt (ctrl_ff[ics_pkg::CTRL_TEST]),
    .i_alt     (test_lvl_ff),
    .o_evt     (speed_evt)
  );

  ics_pulse u_tdc (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_pin     (I_TOP_DEAD_CENTRE_PULSE),
    .i_use_alt (1'b0),
    .i_alt     (1'b0),
    .o_evt     (tdc_evt)
  );

  ics_pulse u_phase (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_pin     (I_PHASE_PICKUP),
    .i_use_alt (1'b0),
    .i_alt     (1'b0),
    .o_evt     (phase_evt)
  );

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      phase_seen_ff <= 1'b0;
      O_SPEED_EVT   <= 1'b0;
      O_TDC_EVT     <= 1'b0;
    end else begin
      O_SPEED_EVT <= speed_evt && !lock_ff;
      if (phase_evt) begin
        phase_seen_ff <= 1'b1;
      end else if (tdc_evt) begin
        phase_seen_ff <= 1'b0;
      end
      if (ctrl_ff[ics_pkg::CTRL_FOUR_CYC]) begin
        O_TDC_EVT <= tdc_evt && (phase_seen_ff || phase_evt) && !lock_ff; // [RULE_14]
      end else begin
        O_TDC_EVT <= tdc_evt && !lock_ff; // [RULE_14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discrete outputs and indicators.

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      net_s_ff                  <= 2'h0;
      O_DISCRETE_OUT_ONE        <= 1'b0;
      O_DISCRETE_OUT_TWO        <= 1'b0;
      O_DO_ONE_INDICATOR        <= 1'b0;
      O_DO_TWO_INDICATOR        <= 1'b0;
      O_FIELD_NETWORK_INDICATOR <= 1'b0;
    end else begin
      net_s_ff                  <= {net_s_ff[0], I_NET_ACTIVITY};
      O_DISCRETE_OUT_ONE        <= ctrl_ff[ics_pkg::CTRL_DO1] && !lock_ff;
      O_DISCRETE_OUT_TWO        <= ctrl_ff[ics_pkg::CTRL_DO2] && !lock_ff;
      O_DO_ONE_INDICATOR        <= ctrl_ff[ics_pkg::CTRL_DO1] && !lock_ff; // [RULE_11]
      O_DO_TWO_INDICATOR        <= ctrl_ff[ics_pkg::CTRL_DO2] && !lock_ff; // [RULE_11]
      O_FIELD_NETWORK_INDICATOR <= net_s_ff[1]; // [RULE_12]
    end
  end
endmodule : ics_top

// ---- ics_pkg.sv ----
// Purpose: Shared constants for the injection command output stage.
// Assumes: 10 MHz system clock, Avalon-MM register bus with 32-bit data.
// Notes:   Long counts are derived here and passed as top-level parameters.
package ics_pkg;

  localparam int          CLK_HZ         = 10_000_000;
  localparam int          NUM_LINES      = 10;
  localparam int          NUM_CH         = 20;
  localparam int          MS_CYC         = CLK_HZ / 1000;

  // Pull-in is 1 to 4 ms, selected by a two-bit field.
  localparam int          PULLIN_MIN_MS  = 1;
  localparam int          PULLIN_MAX_MS  = 4;
  localparam int          HOLD_MAX_MS    = 450;
  localparam int          HOLD_MAX_CYC   = HOLD_MAX_MS * MS_CYC;
  localparam int          TMR_W          = 23;

  // Test rotation: 37.5 rpm (kept in tenths) on a 60-tooth wheel.
  localparam int          TEST_RPM_X10   = 375;
  localparam int          TEST_TEETH     = 60;
  localparam longint      TEST_HALF_CYC  =
    (longint'(CLK_HZ) * 600) / (longint'(TEST_RPM_X10) * TEST_TEETH * 2);

  localparam int          WDOG_MS        = 100;
  localparam int          WDOG_CYC       = WDOG_MS * MS_CYC;

  // Register byte addresses.
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_KICK      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  ADDR_DRIVE     = 8'h14;
  localparam logic [7:0]  ADDR_CMD       = 8'h18;
  localparam logic [7:0]  ADDR_BANK_CLR  = 8'h1c;
  // Memory-mapped I/O window: four selects, each on every fourth word.
  localparam logic [1:0]  MMIO_TOP       = 2'h2;
  localparam int          MMIO_NUM       = 4;

  // Control register fields.
  localparam int          CTRL_FOUR_CYC  = 0;
  localparam int          CTRL_TEST      = 1;
  localparam int          CTRL_WDOG_EN   = 2;
  localparam int          CTRL_DO1       = 3;
  localparam int          CTRL_DO2       = 4;
  localparam int          CTRL_PULL_LO   = 5;
  localparam int          CTRL_W         = 7;
  localparam logic [6:0]  CTRL_RST       = 7'h00;

  // Interrupt status fields.
  localparam int          IRQ_WDOG       = 0;
  localparam int          IRQ_TDC        = 1;
  localparam int          IRQ_HOLD       = 2;
  localparam int          IRQ_SPEED      = 3;
  localparam int          IRQ_W          = 4;

  // Status register fields.
  localparam int          STAT_LOCK      = 0;
  localparam int          STAT_PHASE_ARM = 1;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } ics_bus_st_t;

  function automatic logic [15:0] ics_pull_cyc(input logic [1:0] sel,
                                               input int        ms_cyc);
    ics_pull_cyc = 16'((int'(sel) + PULLIN_MIN_MS) * ms_cyc);
  endfunction : ics_pull_cyc

endpackage : ics_pkg

// ---- ics_drv_if.sv ----
// Purpose: Carries per-cylinder commands and driver state between modules.
// Assumes: All signals on the system clock.
// Notes:   Command, current and drive vectors hold one bit per driver channel; pull_cyc is a 16-bit cycle count.
interface ics_drv_if;
  logic [ics_pkg::NUM_CH-1:0] cmd;
  logic [ics_pkg::NUM_CH-1:0] cur_high;
  logic [15:0]                pull_cyc;
  logic                       lock;
  logic [ics_pkg::NUM_CH-1:0] drive;
  logic                       hold_hit;

  modport ctl (output cmd, output cur_high, output pull_cyc, output lock,
               input drive, input hold_hit);
  modport drv (input cmd, input cur_high, input pull_cyc, input lock,
               output drive, output hold_hit);
endinterface : ics_drv_if

// ---- ics_pulse.sv ----
// Purpose: Conditions one pickup pulse into a one-cycle event.
// Assumes: Pin input is asynchronous; alternate level is on the system clock.
// Notes:   Event fires on the falling edge that follows an arming rising edge.
module ics_pulse (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  input  wire logic i_use_alt,
  input  wire logic i_alt,
  output logic      o_evt
);
  logic sync1_ff;
  logic sync2_ff;
  logic lvl_ff;
  logic armed_ff;
  logic lvl;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
    end
  end

  assign lvl = i_use_alt ? i_alt : sync2_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl_ff   <= 1'b0;
      armed_ff <= 1'b0;
      o_evt    <= 1'b0;
    end else begin
      lvl_ff <= lvl;
      o_evt  <= 1'b0;
      if (lvl && !lvl_ff) begin
        armed_ff <= 1'b1; // [RULE_13]
      end else if (!lvl && lvl_ff && armed_ff) begin
        armed_ff <= 1'b0;
        o_evt    <= 1'b1; // [RULE_13]
      end
    end
  end
endmodule : ics_pulse

// ---- ics_driver.sv ----
// Purpose: Pull-in, hold-in and current-regulated hold for every channel.
// Assumes: Current sense is already synchronised; high means above hold level.
// Notes:   Elapsed time counts from the command's leading edge.
module ics_driver #(
  parameter int P_HOLD_CYC = ics_pkg::HOLD_MAX_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  ics_drv_if.drv    bus
);
  localparam logic [ics_pkg::TMR_W-1:0] HOLD_LIM = ics_pkg::TMR_W'(P_HOLD_CYC);

  logic [ics_pkg::TMR_W-1:0] elapsed_ff [ics_pkg::NUM_CH];
  logic [ics_pkg::NUM_CH-1:0] cmd_d_ff;
  logic [ics_pkg::NUM_CH-1:0] expired_ff;
  logic [ics_pkg::NUM_CH-1:0] drive_ff;
  logic [ics_pkg::NUM_CH-1:0] hit;
  logic                       hit_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_d_ff   <= '0;
      expired_ff <= '0;
      drive_ff   <= '0;
      for (int c = 0; c < ics_pkg::NUM_CH; c++) begin
        elapsed_ff[c] <= '0;
      end
    end else begin
      cmd_d_ff <= bus.cmd;
      for (int c = 0; c < ics_pkg::NUM_CH; c++) begin
        if (!bus.cmd[c] || !cmd_d_ff[c]) begin
          elapsed_ff[c] <= '0; // [RULE_05]
          expired_ff[c] <= 1'b0;
        end else if (bus.cmd[c] && !expired_ff[c]) begin
          elapsed_ff[c] <= elapsed_ff[c] + 1'b1;
          if (elapsed_ff[c] + 1'b1 >= HOLD_LIM) begin
            expired_ff[c] <= 1'b1; // [RULE_07]
          end
        end
        if (bus.lock || !bus.cmd[c] || expired_ff[c] || hit[c]) begin
          drive_ff[c] <= 1'b0; // [RULE_04] [RULE_02]
        end else if (elapsed_ff[c] < ics_pkg::TMR_W'(bus.pull_cyc)) begin
          drive_ff[c] <= 1'b1; // [RULE_06]
        end else begin
          drive_ff[c] <= !bus.cur_high[c]; // [RULE_08]
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < ics_pkg::NUM_CH; c++) begin
      hit[c] = bus.cmd[c] && !expired_ff[c] && (elapsed_ff[c] + 1'b1 >= HOLD_LIM);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= |hit;
    end
  end

  assign bus.drive    = drive_ff;
  assign bus.hold_hit = hit_ff;
endmodule : ics_driver

// ---- ics_checker.sv ----
// Purpose: Port checks for the injection command output stage.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Bound to the top module by the bench.
module ics_checker (
  input wire logic        I_CLK,
  input wire logic        I_RESETN,
  input wire logic [7:0]  I_AVS_ADDRESS,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic [19:0] O_INJ_CMD,
  input wire logic [19:0] O_SOL_DRIVE,
  input wire logic        O_CPU_HALT,
  input wire logic        O_IO_LOCK,
  input wire logic [3:0]  O_MMIO_SEL,
  input wire logic        O_CPU_RUN_INDICATOR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  ////////////////////////////////////////////////////////////////
  AST_LOCK_QUIET: assert property (O_IO_LOCK |=> (O_INJ_CMD | O_SOL_DRIVE) == 20'h0)
    else $error("output active while locked");
  AST_LOCK_HOLD: assert property (O_IO_LOCK |=> O_IO_LOCK)
    else $error("lock released");
  AST_HALT_LOCK: assert property (O_CPU_HALT == O_IO_LOCK)
    else $error("halt differs from lock");
  AST_RUN_LAMP: assert property ($past(I_RESETN) |-> O_CPU_RUN_INDICATOR != O_IO_LOCK)
    else $error("run lamp wrong");
  AST_ONE_WAIT: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=>
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST) else $error("bus answer timing");
  AST_MMIO_SEL: assert property (I_AVS_WRITE && O_AVS_WAITREQUEST && I_AVS_ADDRESS[7:6] == 2'h2
    |-> ##[1:2] O_MMIO_SEL == 4'h1 << I_AVS_ADDRESS[3:2]) else $error("select missing");
  AST_NO_CMD: assert property ((O_SOL_DRIVE & ~O_INJ_CMD & ~$past(O_INJ_CMD)
    & ~$past(O_INJ_CMD, 2) & ~$past(O_INJ_CMD, 3)) == 20'h0) else $error("drive without command");
  AST_PULL_START: assert property ($rose(O_INJ_CMD[6]) |-> ##2
    O_SOL_DRIVE[6] || O_IO_LOCK) else $error("pull-in not started");
  cover property ($rose(O_IO_LOCK));
  cover property ($rose(O_SOL_DRIVE[7]));
  cover property (O_MMIO_SEL != 4'h0);
endmodule : ics_checker

// ---- ics_cpu_model.sv ----
// Purpose: Processor side driving the ten injection lines.
// Assumes: The bench asks for one pulse at a time.
// Notes:   A line's pulses alternate between its two cylinders.
module ics_cpu_model (
  input  wire logic       i_clk,
  output logic      [9:0] o_line
);
  initial o_line = 10'h000;
  // One injection pulse of len cycles on line ln.
  task automatic fire(input int ln, input int len);
    @(posedge i_clk);
    o_line[ln] <= 1'b1;
    repeat (len) @(posedge i_clk);
    o_line[ln] <= 1'b0;
  endtask : fire
endmodule : ics_cpu_model

// ---- ics_top_tb.sv ----
// Purpose: Self-checking bench for the injection command output stage.
// Assumes: Long counts shortened by parameters; 10 MHz clock.
// Notes:   Bus accesses and pickup pulses go through tasks.
module ics_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        I_CLK, I_RESETN, I_AVS_READ, I_AVS_WRITE, I_NET_ACTIVITY, O_AVS_WAITREQUEST;
  logic        I_SPEED_PICKUP, I_TOP_DEAD_CENTRE_PULSE, I_PHASE_PICKUP, O_SPEED_EVT, O_TDC_EVT;
  logic        O_CPU_HALT, O_IO_LOCK, O_SUPPLY_PRESENT_INDICATOR, O_CPU_RUN_INDICATOR, O_IRQ;
  logic        O_DISCRETE_OUT_ONE, O_DISCRETE_OUT_TWO, O_DO_ONE_INDICATOR, O_DO_TWO_INDICATOR;
  logic        O_FIELD_NETWORK_INDICATOR;
  logic [2:0]  pk;
  logic [3:0]  O_MMIO_SEL, mm_seen;
  logic [7:0]  I_AVS_ADDRESS;
  logic [9:0]  I_INJ_LINE;
  logic [19:0] I_CUR_HIGH, O_INJ_CMD, O_SOL_DRIVE;
  logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, rdat;
  int          fail_count, n_tests, cyc, n_spd, n_tdc, n0;
  assign {I_PHASE_PICKUP, I_TOP_DEAD_CENTRE_PULSE, I_SPEED_PICKUP} = pk;
  ics_top #(.P_MS_CYC(10), .P_HOLD_CYC(200), .P_TEST_HALF(20), .P_WDOG_CYC(100)) uut (.*);
  ics_cpu_model cpu (.i_clk(I_CLK), .o_line(I_INJ_LINE));
  always #50 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cyc++;
    if (O_SPEED_EVT === 1'b1) n_spd++;
    if (O_TDC_EVT === 1'b1) n_tdc++;
    mm_seen |= O_MMIO_SEL;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic s(input int n);
    repeat (n) @(posedge I_CLK);
    @(negedge I_CLK);
  endtask : s
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    {I_AVS_ADDRESS, I_AVS_WRITEDATA} <= {a, d};
    {I_AVS_WRITE, I_AVS_READ} <= {w, !w};
    do @(posedge I_CLK); while (O_AVS_WAITREQUEST !== 1'b0);
    {I_AVS_WRITE, I_AVS_READ} <= 2'h0;
    rdat = O_AVS_READDATA;
  endtask : bus
  task automatic pulse(input int k);
    int b;
    b = n_spd + n_tdc;
    @(posedge I_CLK);
    pk[k] <= 1'b1;
    s(6);
    chk(n_spd + n_tdc, b);
    @(posedge I_CLK);
    pk[k] <= 1'b0;
    s(8);
  endtask : pulse
  task automatic conclude();
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    {I_CLK, I_RESETN, I_AVS_READ, I_AVS_WRITE, I_NET_ACTIVITY, pk, mm_seen} = '0;
    {I_AVS_ADDRESS, I_AVS_WRITEDATA} = '0;
    I_CUR_HIGH = 20'hfffff;
    repeat (8) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    bus(1'b1, 8'h00, 32'h19);
    bus(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h19);
    chk({O_DO_ONE_INDICATOR, O_DO_TWO_INDICATOR, O_DISCRETE_OUT_TWO}, 3'h7);
    chk(O_SUPPLY_PRESENT_INDICATOR, 1'h1);
    bus(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, 8'h84, 32'h0);
    s(2);
    chk(mm_seen, 4'h2);
    bus(1'b1, 8'h00, 32'h0);
    $display("decode done");
    fork
      cpu.fire(3, 30);
      begin
        s(8);
        chk({O_INJ_CMD[6], O_SOL_DRIVE[6]}, 2'h3);
        s(17);
        chk({O_INJ_CMD[6], O_SOL_DRIVE[6]}, 2'h2);
      end
    join
    s(6);
    chk(O_INJ_CMD | O_SOL_DRIVE, 20'h0);
    bus(1'b1, 8'h00, 32'h60);
    fork
      cpu.fire(3, 50);
      begin
        s(30);
        chk({O_INJ_CMD[7:6], O_SOL_DRIVE[7]}, 3'h5);
        s(18);
        chk({O_INJ_CMD[7:6], O_SOL_DRIVE[7]}, 3'h4);
      end
    join
    s(6);
    @(posedge I_CLK);
    I_CUR_HIGH <= 20'h0;
    fork
      cpu.fire(3, 300);
      begin
        s(260);
        chk({O_INJ_CMD[6], O_SOL_DRIVE[6]}, 2'h2);
      end
    join
    bus(1'b0, 8'h0c, 32'h0);
    chk(rdat & 32'h4, 32'h4);
    $display("driver done");
    bus(1'b1, 8'h0c, 32'hf);
    pulse(0);
    chk(n_spd, 1);
    bus(1'b1, 8'h00, 32'h1);
    pulse(1);
    chk(n_tdc, 0);
    pulse(2);
    pulse(1);
    chk({n_tdc[3:0], O_IRQ}, 5'h2);
    bus(1'b1, 8'h10, 32'h2);
    s(2);
    chk(O_IRQ, 1'h1);
    bus(1'b1, 8'h0c, 32'h2);
    s(2);
    chk(O_IRQ, 1'h0);
    chk(32'(ics_pkg::TEST_HALF_CYC), 32'h0002_08d5);
    n0 = n_spd;
    bus(1'b1, 8'h00, 32'h2);
    s(400);
    chk(n_spd - n0 inside {[9:11]}, 1'h1);
    $display("pickup done");
    bus(1'b1, 8'h00, 32'hc);
    @(posedge I_CLK);
    I_NET_ACTIVITY <= 1'b1;
    s(5);
    chk(O_FIELD_NETWORK_INDICATOR, 1'h1);
    repeat (3) begin
      s(60);
      bus(1'b1, 8'h04, 32'h0);
    end
    chk(O_IO_LOCK, 1'h0);
    s(150);
    chk({O_IO_LOCK, O_CPU_HALT, O_DISCRETE_OUT_ONE, O_DO_ONE_INDICATOR}, 4'hc);
    chk(O_CPU_RUN_INDICATOR, 1'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h1);
    fork
      cpu.fire(0, 20);
      begin
        s(10);
        chk(O_INJ_CMD | O_SOL_DRIVE, 20'h0);
      end
    join
    $display("watchdog done");
    conclude();
  end
endmodule : ics_top_tb
bind ics_top ics_checker chk_u (.*);
